// ### include/accel_spi_defs.svh
// Offsets, field positions, reset values and timing counts of the control port
`ifndef ACCEL_SPI_DEFS_SVH
`define ACCEL_SPI_DEFS_SVH

// ****************************************************************
// Frame
// ****************************************************************
`define ACC_FRAME_BITS      16
`define ACC_COUNT_MAX       5'h1f

// ****************************************************************
// Request word
// ****************************************************************
`define ACC_REQ_OP_HI       15
`define ACC_REQ_OP_LO       14
`define ACC_REQ_SEN         13
`define ACC_REQ_SEQ1        15
`define ACC_REQ_SEQ0        14
`define ACC_REQ_SEQ2        12
`define ACC_REQ_DATA_HI     7
`define ACC_REQ_DATA_LO     0
`define ACC_REQ_LC_HI       3
`define ACC_REQ_LC_LO       0
`define ACC_OP_WRITE        2'h1
`define ACC_OP_READ         2'h2

// ****************************************************************
// Response word
// ****************************************************************
`define ACC_RSP_PAR         12
`define ACC_RSP_FLE         2
`define ACC_RSP_RE          1
`define ACC_RSP_DU          0
`define ACC_RSP_CNC         3
`define ACC_RSP_HE          2
`define ACC_KIND_NONSENSOR  2'h3
`define ACC_KIND_SELFTEST   2'h2
`define ACC_KIND_DATA       2'h1
`define ACC_EXC_NONSENSOR   2'h2
`define ACC_EXC_SENSOR      2'h0
`define ACC_RSP_RESET       16'h0e03

// ****************************************************************
// Control register sensor_control
// ****************************************************************
`define ACC_CTRL_FREEZE_HI  1
`define ACC_CTRL_FREEZE_LO  0
`define ACC_CTRL_FRST       2
`define ACC_CTRL_FTST_HI    4
`define ACC_CTRL_FTST_LO    3
`define ACC_CTRL_TC         5
`define ACC_CTRL_ST         6
`define ACC_CTRL_PD         7
`define ACC_CTRL_RESET      8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define ACC_SETTLE_MS       60
`define ACC_CLK_KHZ         40000
`define ACC_SETTLE_CYCLES   (`ACC_SETTLE_MS * `ACC_CLK_KHZ)

`endif

// ### include/accel_spi_pkg.sv
// Types shared by the accelerometer control port
package accel_spi_pkg;

  typedef enum logic [1:0] {
    FREEZE_ALL  = 2'h0,
    FREEZE_AXIS = 2'h1,
    FREEZE_MSB  = 2'h2,
    FREEZE_NONE = 2'h3
  } freeze_mode_type;

  typedef struct packed {
    logic [15:0] shift;
    logic [4:0]  count;
  } link_state_type;

  typedef struct packed {
    logic        ss_meta;
    logic        ss_sync;
    logic        ss_prev;
    logic [15:0] resp;
    logic [7:0]  ctrl;
    logic [3:0]  pending;
    logic [13:0] x_hold;
    logic [13:0] y_hold;
    logic [1:0]  phase;
    logic [21:0] settle_cnt;
    logic        settled;
  } core_state_type;

endpackage : accel_spi_pkg

// ### design/accel_spi_control_port.sv
// SPI slave control port of a dual-axis accelerometer
`timescale 1ns/1ps
`include "accel_spi_defs.svh"

module accel_spi_control_port #(
  parameter int unsigned SETTLE_CYCLES = `ACC_SETTLE_CYCLES
) (
  input  wire logic                          sys_clk,
  input  wire logic                          rst_n,
  input  wire logic                          sck,
  input  wire logic                          slave_select_n,
  input  wire logic                          mosi,
  output logic                               miso_out,
  output logic                               miso_oe_n,
  input  wire logic [13:0]                   x_sample,
  input  wire logic [13:0]                   y_sample,
  input  wire logic                          sample_valid,
  input  wire logic                          heater_loop_fault,
  input  wire logic                          modulator_bit,
  output logic                               filter_input_bit,
  output logic                               filter_reset,
  output logic                               test_pattern_settled,
  output logic                               tempcomp_off,
  output logic                               self_test_on,
  output logic                               power_down,
  output accel_spi_pkg::freeze_mode_type     freeze_mode
);
  import accel_spi_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************

  // Odd parity over the whole word, bit 12 supplies the balance
  function automatic logic [15:0] with_parity(input logic [15:0] word);
    logic [15:0] w;
    w = word;
    w[`ACC_RSP_PAR] = 1'b0;
    w[`ACC_RSP_PAR] = ~(^w);
    return w;
  endfunction : with_parity

  // Byte group that a read of byte b opens, b itself included; bit 0 x lsb, 1 y lsb, 2 x msb, 3 y msb
  function automatic logic [3:0] freeze_group(input freeze_mode_type mode,
                                              input logic [1:0] b);
    logic [3:0] g;
    g = 4'h0;
    case (mode)
      FREEZE_ALL:  g = 4'hf;
      FREEZE_AXIS: g = b[0] ? 4'ha : 4'h5;
      FREEZE_MSB:  g = b[1] ? 4'hc : 4'h0;
      FREEZE_NONE: g = 4'h0;
      default:     g = 4'h0;
    endcase
    return g;
  endfunction : freeze_group

  function automatic logic [15:0] error_word(input logic fle,
                                             input logic re,
                                             input logic du);
    logic [15:0] w;
    w = 16'h0000;
    w[11:10] = `ACC_KIND_NONSENSOR;
    w[9:8] = `ACC_EXC_NONSENSOR;
    w[`ACC_RSP_FLE] = fle;
    w[`ACC_RSP_RE] = re;
    w[`ACC_RSP_DU] = du;
    return with_parity(w);
  endfunction : error_word

  // Only write and read exist for the control register
  function automatic logic known_op(input logic [1:0] op);
    return (op == `ACC_OP_WRITE) || (op == `ACC_OP_READ);
  endfunction : known_op

  // Granted register answer: echoed opcode, fixed codes, register contents
  function automatic logic [15:0] register_word(input logic [1:0] op,
                                                input logic [7:0] data);
    logic [15:0] w;
    w = 16'h0000;
    w[14:13] = op;
    w[11:10] = `ACC_KIND_NONSENSOR;
    w[9:8] = `ACC_EXC_NONSENSOR;
    w[7:0] = data;
    return with_parity(w);
  endfunction : register_word

  // ****************************************************************
  // Link side, on the master's clock
  // ****************************************************************
  link_state_type link_q;
  link_state_type next_link;
  logic           armed;
  logic           arm_set;

  // Armed marks a frame whose first edge has not come yet; select high re-arms it
  assign arm_set = ~rst_n | slave_select_n;

  always_ff @(posedge sck or posedge arm_set) begin
    if (arm_set) begin
      armed <= 1'b1;
    end else begin
      armed <= 1'b0;
    end
  end

  always_comb begin
    next_link = link_q;
    if (armed) begin
      next_link.shift = {15'h0000, mosi};
      next_link.count = 5'h01;
    end else begin
      next_link.shift = {link_q.shift[14:0], mosi};
      if (link_q.count != `ACC_COUNT_MAX) begin
        next_link.count = link_q.count + 5'h01;
      end
    end
  end

  // Shift and count are not cleared at frame end: the core reads them while SCK is idle
  always_ff @(posedge sck or negedge rst_n) begin
    if (!rst_n) begin
      link_q <= '0;
    end else begin
      link_q <= next_link;
    end
  end

  // ****************************************************************
  // MISO
  // ****************************************************************
  core_state_type core_q;
  core_state_type next_core;
  logic [4:0]     bit_index;

  // Response word only changes between frames, so it is steady while shifted out
  assign bit_index = armed ? 5'h00 : link_q.count;
  assign miso_out = (bit_index < 5'(`ACC_FRAME_BITS))
                    ? core_q.resp[4'(15 - int'(bit_index))] : 1'b0;
  assign miso_oe_n = slave_select_n;

  // ****************************************************************
  // Core side
  // ****************************************************************
  logic            frame_done;
  logic [15:0]     req;
  logic [4:0]      req_len;
  logic            len_ok;
  logic [1:0]      req_op;
  logic [1:0]      byte_sel;
  logic [9:0]      sensor_data;
  logic [15:0]     rsp;
  logic            sensor_read;
  logic            freeze_x;
  logic            freeze_y;
  logic [1:0]      pattern_code;
  freeze_mode_type mode;

  assign mode = freeze_mode_type'(core_q.ctrl[`ACC_CTRL_FREEZE_HI:`ACC_CTRL_FREEZE_LO]);
  assign pattern_code = core_q.ctrl[`ACC_CTRL_FTST_HI:`ACC_CTRL_FTST_LO];

  always_comb begin
    next_core = core_q;
    rsp = core_q.resp;
    sensor_read = 1'b0;
    sensor_data = 10'h000;

    // Select is a pin: two stages before anything looks at it
    next_core.ss_meta = slave_select_n;
    next_core.ss_sync = core_q.ss_meta;
    next_core.ss_prev = core_q.ss_sync;
    frame_done = core_q.ss_sync & ~core_q.ss_prev;

    req = link_q.shift;
    req_len = link_q.count;
    len_ok = (req_len == 5'(`ACC_FRAME_BITS));
    req_op = req[`ACC_REQ_OP_HI:`ACC_REQ_OP_LO];
    byte_sel = req[1:0];

    // Axis freeze from the outstanding byte mask
    freeze_x = (mode == FREEZE_AXIS) ? (core_q.pending[0] | core_q.pending[2])
                                     : (|core_q.pending);
    freeze_y = (mode == FREEZE_AXIS) ? (core_q.pending[1] | core_q.pending[3])
                                     : (|core_q.pending);

    // Byte of the held sample: MSB register holds top ten bits, LSB the low four
    case (byte_sel)
      2'h0:    sensor_data = {6'h00, core_q.x_hold[3:0]};
      2'h1:    sensor_data = {6'h00, core_q.y_hold[3:0]};
      2'h2:    sensor_data = core_q.x_hold[13:4];
      2'h3:    sensor_data = core_q.y_hold[13:4];
      default: sensor_data = 10'h000;
    endcase

    if (frame_done) begin
      if (!len_ok) begin
        rsp = error_word(1'b1, 1'b0, 1'b0);
      end else if (req[`ACC_REQ_SEN]) begin
        rsp = 16'h0000;
        rsp[15:13] = {req[`ACC_REQ_SEQ2], req[`ACC_REQ_SEQ1], req[`ACC_REQ_SEQ0]};
        if (core_q.ctrl[`ACC_CTRL_PD] || heater_loop_fault) begin
          rsp[11:10] = `ACC_KIND_NONSENSOR;
          rsp[9:8] = `ACC_EXC_SENSOR;
          rsp[`ACC_RSP_CNC] = core_q.ctrl[`ACC_CTRL_PD];
          rsp[`ACC_RSP_HE] = heater_loop_fault;
        end else begin
          sensor_read = 1'b1;
          rsp[11:10] = (core_q.ctrl[`ACC_CTRL_ST] || core_q.ctrl[`ACC_CTRL_TC])
                       ? `ACC_KIND_SELFTEST : `ACC_KIND_DATA;
          rsp[9:0] = sensor_data;
        end
        rsp = with_parity(rsp);
      end else if (known_op(req_op)) begin
        // Address field plays no part: one register only
        if (req_op == `ACC_OP_WRITE) begin
          next_core.ctrl = req[`ACC_REQ_DATA_HI:`ACC_REQ_DATA_LO];
        end
        rsp = register_word(req_op, next_core.ctrl);
      end else begin
        rsp = error_word(1'b0, 1'b1, 1'b0);
      end
      next_core.resp = rsp;
    end

    // Outstanding bytes: a fresh read opens a group, later reads pay it off
    if (sensor_read) begin
      if ((core_q.pending & freeze_group(mode, byte_sel)) == 4'h0) begin
        next_core.pending = core_q.pending | (freeze_group(mode, byte_sel)
                            & ~(4'h1 << byte_sel));
      end else begin
        next_core.pending = core_q.pending & ~(4'h1 << byte_sel);
      end
    end
    if (mode == FREEZE_NONE) begin
      next_core.pending = 4'h0;
    end

    // Output registers; filter reset forces zero and drops any freeze
    if (core_q.ctrl[`ACC_CTRL_FRST]) begin
      next_core.x_hold = 14'h0000;
      next_core.y_hold = 14'h0000;
      next_core.pending = 4'h0;
    end else if (sample_valid) begin
      if (!freeze_x) begin
        next_core.x_hold = x_sample;
      end
      if (!freeze_y) begin
        next_core.y_hold = y_sample;
      end
    end

    // Pattern generator: density of ones is pattern code quarters
    next_core.phase = core_q.phase + 2'h1;

    // Settling window restarts whenever the pattern is off or changes
    if (pattern_code == 2'h0
        || next_core.ctrl[`ACC_CTRL_FTST_HI:`ACC_CTRL_FTST_LO] != pattern_code) begin
      next_core.settle_cnt = 22'h000000;
      next_core.settled = 1'b0;
    end else if (core_q.settle_cnt >= 22'(SETTLE_CYCLES - 1)) begin
      next_core.settled = 1'b1;
    end else begin
      next_core.settle_cnt = core_q.settle_cnt + 22'h000001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      core_q <= '0;
      core_q.ss_meta <= 1'b1;
      core_q.ss_sync <= 1'b1;
      core_q.ss_prev <= 1'b1;
      core_q.ctrl <= `ACC_CTRL_RESET;
      // Answer to the first frame: request error with data unavailable
      core_q.resp <= `ACC_RSP_RESET;
    end else begin
      core_q <= next_core;
    end
  end

  // ****************************************************************
  // Controls toward the datapath
  // ****************************************************************
  // Power-down gates only sensor reads here, not these outputs; the analog side owns the current switch
  assign filter_reset = core_q.ctrl[`ACC_CTRL_FRST];
  assign tempcomp_off = core_q.ctrl[`ACC_CTRL_TC];
  assign self_test_on = core_q.ctrl[`ACC_CTRL_ST];
  assign power_down = core_q.ctrl[`ACC_CTRL_PD];
  assign freeze_mode = mode;
  assign test_pattern_settled = core_q.settled;
  assign filter_input_bit = (pattern_code == 2'h0) ? modulator_bit
                            : (core_q.phase < pattern_code);

endmodule : accel_spi_control_port

// ### tb/spi_master_model.sv
// SPI master model standing at the link side of the control port
`timescale 1ns/1ps
module spi_master_model (
  output logic     sck,
  output logic     slave_select_n,
  output logic     mosi,
  input wire logic miso_out,
  input wire logic miso_oe_n
);
  // ********************************
  // Link drive
  // ********************************
  logic last_bit;
  logic miso_line;
  // A released line shows the inverse of the last bit, so stale data never passes
  assign miso_line = miso_oe_n ? ~last_bit : miso_out;
  initial begin
    sck = 1'b0;
    slave_select_n = 1'b1;
    mosi = 1'b0;
    last_bit = 1'b0;
  end
  // Clock stands low outside frames; 48 ns period inside
  task automatic xfer(input logic [15:0] req, input int n, output logic [15:0] rsp);
    rsp = 16'h0;
    slave_select_n = 1'b0;
    for (int i = 0; i < n; i++) begin
      mosi = req[15 - (i % 16)];
      #23;
      rsp = {rsp[14:0], miso_line};
      last_bit = miso_line;
      #1 sck = 1'b1;
      #24 sck = 1'b0;
    end
    #24 slave_select_n = 1'b1;
  endtask : xfer
endmodule : spi_master_model

// ### tb/accel_spi_control_port_checker.sv
// Concurrent checks on the ports of the accelerometer SPI control port
`timescale 1ns/1ps
module accel_spi_control_port_checker (
  input wire logic                     sys_clk,
  input wire logic                     rst_n,
  input wire logic                     sck,
  input wire logic                     slave_select_n,
  input wire logic                     mosi,
  input wire logic                     miso_out,
  input wire logic                     miso_oe_n,
  input wire logic                     filter_input_bit,
  input wire logic                     filter_reset,
  input wire logic                     test_pattern_settled,
  input wire logic                     tempcomp_off,
  input wire logic                     self_test_on,
  input wire logic                     power_down,
  input accel_spi_pkg::freeze_mode_type freeze_mode
);
  import accel_spi_pkg::*;
  // ********************************
  // Frame capture
  // ********************************
  logic [15:0] cap;
  logic [15:0] req;
  logic [15:0] prev_req;
  logic [4:0]  cnt;
  logic        first;
  logic        prev_bad;
  logic [5:0]  ctl;
  assign ctl = {power_down, self_test_on, tempcomp_off, filter_reset, freeze_mode};
  // Each bit is taken at the edge after it, as the master does
  always_ff @(posedge sck or posedge slave_select_n) begin
    if (slave_select_n) begin
      cnt <= 5'h0;
    end else begin
      cap <= {cap[14:0], miso_out};
      req <= {req[14:0], mosi};
      cnt <= (cnt == 5'h1f) ? cnt : cnt + 5'h1;
    end
  end
  always_ff @(posedge slave_select_n or negedge rst_n) begin
    if (!rst_n) begin
      first <= 1'b1;
      prev_bad <= 1'b0;
      prev_req <= 16'h0000;
    end else begin
      first <= 1'b0;
      prev_bad <= (cnt != 5'h10);
      prev_req <= req;
    end
  end
  // ********************************
  // Assertions
  // ********************************
  a_parity_odd: assert property (@(posedge slave_select_n) disable iff (!rst_n)
    cnt == 5'h10 |-> ^cap) else $error("response parity even");
  a_kind_legal: assert property (@(posedge slave_select_n) disable iff (!rst_n)
    cnt == 5'h10 |-> cap[11:10] != 2'h0 && (cap[11:10] != 2'h3 || cap[9:8] inside {2'h0, 2'h2}))
    else $error("response kind or exception code wrong");
  a_error_clean: assert property (@(posedge slave_select_n) disable iff (!rst_n)
    cnt == 5'h10 && !first && (prev_bad || (!prev_req[13] && prev_req[15] == prev_req[14]))
    |-> cap[14:13] == 2'h0 && cap[11:8] == 4'he && cap[7:3] == 5'h0)
    else $error("error response carries stray bits");
  a_first_error: assert property (@(posedge slave_select_n) disable iff (!rst_n)
    cnt == 5'h10 && first |-> cap == 16'h0e03) else $error("first response after reset wrong");
  a_length_flag: assert property (@(posedge slave_select_n) disable iff (!rst_n)
    cnt == 5'h10 && prev_bad && !first |-> cap[11:8] == 4'he && cap[2:1] == 2'h2)
    else $error("frame length error not reported");
  a_oe_select: assert property (@(posedge sys_clk) disable iff (!rst_n)
    miso_oe_n == slave_select_n) else $error("output enable does not follow select");
  a_reset_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
    $rose(rst_n) |-> ctl == 6'h0) else $error("control outputs not clear after reset");
  a_ctrl_frame: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !slave_select_n && $past(!slave_select_n) |-> $stable(ctl))
    else $error("control outputs changed inside a frame");
  a_pattern_period: assert property (@(posedge sys_clk) disable iff (!rst_n)
    test_pattern_settled && $past(test_pattern_settled, 4) |-> filter_input_bit == $past(filter_input_bit, 4))
    else $error("test pattern not periodic");
  c_bad_frame: cover property (@(posedge slave_select_n) disable iff (!rst_n) cnt != 5'h10);
  c_first: cover property (@(posedge slave_select_n) disable iff (!rst_n) cnt == 5'h10 && first);
  c_settled: cover property (@(posedge sys_clk) disable iff (!rst_n) $rose(test_pattern_settled));
endmodule : accel_spi_control_port_checker

bind accel_spi_control_port accel_spi_control_port_checker accel_spi_control_port_checker_i (
  .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .slave_select_n(slave_select_n),
  .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .filter_input_bit(filter_input_bit),
  .filter_reset(filter_reset), .test_pattern_settled(test_pattern_settled),
  .tempcomp_off(tempcomp_off), .self_test_on(self_test_on), .power_down(power_down),
  .freeze_mode(freeze_mode));

// ### tb/accel_spi_control_port_tb.sv
// Self-checking bench of the accelerometer SPI control port
`timescale 1ns/1ps
module accel_spi_control_port_tb;
  import accel_spi_pkg::*;
  // ********************************
  // Signals and instances
  // ********************************
  localparam int SETTLE = 50;
  logic sys_clk, rst_n, sck, slave_select_n, mosi, miso_out, miso_oe_n;
  logic [13:0] x_sample, y_sample;
  logic sample_valid, heater_loop_fault, modulator_bit, filter_input_bit, filter_reset;
  logic test_pattern_settled, tempcomp_off, self_test_on, power_down;
  freeze_mode_type freeze_mode;
  logic [15:0] exp_q, ones;
  logic [7:0] v;
  logic [5:0] ctl;
  int error_cnt, checks_done, w;
  assign ctl = {power_down, self_test_on, tempcomp_off, filter_reset, freeze_mode};
  accel_spi_control_port #(.SETTLE_CYCLES(SETTLE)) accel_spi_control_port_i (
    .sys_clk(sys_clk), .rst_n(rst_n), .sck(sck), .slave_select_n(slave_select_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n), .x_sample(x_sample),
    .y_sample(y_sample), .sample_valid(sample_valid), .heater_loop_fault(heater_loop_fault),
    .modulator_bit(modulator_bit), .filter_input_bit(filter_input_bit),
    .filter_reset(filter_reset), .test_pattern_settled(test_pattern_settled),
    .tempcomp_off(tempcomp_off), .self_test_on(self_test_on), .power_down(power_down),
    .freeze_mode(freeze_mode));
  spi_master_model spi_master_model_i (.sck(sck), .slave_select_n(slave_select_n),
    .mosi(mosi), .miso_out(miso_out), .miso_oe_n(miso_oe_n));
  initial sys_clk = 1'b0;
  always #12.5 sys_clk = ~sys_clk;
  // ********************************
  // Helpers
  // ********************************
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("Checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : tally_and_finish
  function automatic logic [15:0] odd(input logic [15:0] x);
    odd = x;
    odd[12] = ~^{x[15:13], x[11:0]};
  endfunction : odd
  function automatic logic [15:0] rr(input logic [1:0] op, input logic [7:0] d);
    rr = odd({1'b0, op, 1'b0, 4'he, d});
  endfunction : rr
  function automatic logic [15:0] sr(input logic [1:0] kind, input logic [9:0] d);
    sr = odd({3'h6, 1'b0, kind, d});
  endfunction : sr
  function automatic logic [15:0] cv(input logic [7:0] c);
    cv = {10'h0, c[7:5], c[2:0]};
  endfunction : cv
  function automatic logic [9:0] sd(input int lc);
    case (lc)
      0: sd = {6'h0, x_sample[3:0]};
      1: sd = {6'h0, y_sample[3:0]};
      2: sd = x_sample[13:4];
      default: sd = y_sample[13:4];
    endcase
  endfunction : sd
  // Each frame returns the answer to the one before it
  task automatic go(input logic [15:0] req, input int n, input logic [15:0] nxt);
    logic [15:0] rsp;
    @(posedge sys_clk);
    #1 spi_master_model_i.xfer(req, n, rsp);
    repeat (6) @(posedge sys_clk);
    if (n == 16) check("miso", rsp, exp_q);
    exp_q = nxt;
  endtask : go
  // ********************************
  // Scenarios
  // ********************************
  initial begin
    #2000000;
    error_cnt++;
    tally_and_finish();
  end
  initial begin
    rst_n = 1'b0;
    x_sample = 14'h2abc;
    y_sample = 14'h1357;
    sample_valid = 1'b1;
    heater_loop_fault = 1'b0;
    modulator_bit = 1'b1;
    error_cnt = 0;
    checks_done = 0;
    for (int r = 0; r < 2; r++) begin
      exp_q = rr(2'h0, 8'h03);
      repeat (3) @(posedge sys_clk);
      #1 rst_n = 1'b1;
      repeat (3) @(posedge sys_clk);
      check("ctrl", {10'h0, ctl}, 16'h0);
      go(16'h4105, 16, rr(2'h1, 8'h05));
      check("ctrl", {10'h0, ctl}, cv(8'h05));
      @(posedge sys_clk);
      #1 rst_n = r[0];
    end
    for (int i = 0; i < 9; i++) begin
      v = (i == 8) ? 8'hff : 8'h01 << i;
      go({3'h2, 5'(i), v}, 16, rr(2'h1, v));
      go({3'h4, 5'h1f, ~v}, 16, rr(2'h2, v));
      check("ctrl", {10'h0, ctl}, cv(v));
    end
    go(16'h00aa, 16, rr(2'h0, 8'h02));
    go(16'hc0aa, 16, rr(2'h0, 8'h02));
    go(16'h8000, 16, rr(2'h2, 8'hff));
    go(16'h4000, 15, rr(2'h0, 8'h04));
    go(16'h8000, 16, rr(2'h2, 8'hff));
    go(16'h4000, 17, rr(2'h0, 8'h04));
    go(16'h8000, 16, rr(2'h2, 8'hff));
    check("ctrl", {10'h0, ctl}, cv(8'hff));
    go(16'h4003, 16, rr(2'h1, 8'h03));
    for (int lc = 0; lc < 4; lc++)
      go({8'hba, 6'h29, 2'(lc)}, 16, sr(2'h1, sd(lc)));
    go(16'h4004, 16, rr(2'h1, 8'h04));
    go(16'hb002, 16, sr(2'h1, 10'h000));
    go(16'h4000, 16, rr(2'h1, 8'h00));
    go(16'hb000, 16, sr(2'h1, sd(0)));
    #1 x_sample = 14'h0555;
    go(16'hb002, 16, sr(2'h1, 10'h2ab));
    go(16'hb001, 16, sr(2'h1, 10'h007));
    go(16'hb003, 16, sr(2'h1, 10'h135));
    go(16'hb002, 16, sr(2'h1, 10'h055));
    go(16'h4043, 16, rr(2'h1, 8'h43));
    go(16'hb002, 16, sr(2'h2, sd(2)));
    go(16'h4003, 16, rr(2'h1, 8'h03));
    #1 heater_loop_fault = 1'b1;
    go(16'hb002, 16, sr(2'h3, 10'h004));
    #1 heater_loop_fault = 1'b0;
    go(16'h4083, 16, rr(2'h1, 8'h83));
    go(16'hb002, 16, sr(2'h3, 10'h008));
    for (int k = 0; k < 4; k++) begin
      go({8'h40, 3'h0, 2'(k), 3'h3}, 16, rr(2'h1, {3'h0, 2'(k), 3'h3}));
      ones = 16'h0;
      repeat (8) begin
        @(posedge sys_clk);
        #1 ones = ones + 16'(filter_input_bit);
      end
      check("pattern", ones, (k == 0) ? 16'h8 : 16'(2 * k));
      for (w = 0; w < SETTLE + 20 && test_pattern_settled !== 1'b1; w++) @(posedge sys_clk);
      check("settled", {15'h0, test_pattern_settled}, {15'h0, k != 0});
      if (w == SETTLE + 20 && k != 0) tally_and_finish();
    end
    tally_and_finish();
  end
endmodule : accel_spi_control_port_tb
